/* File: src/scs_sequencer.sv */
/*
  Storage class sequencer: takes read and write commands, classes the
  address and dispatches subcommands to the core, drum and register
  access controllers, or raises a fault.
  Assumes commands, stepping pulses and drum resume come from logic on
  core_clk, so none of them is synchronised here.
*/
// How it works
// - Sequences start on command or subcommand
// - First step lands with initiating command
// - Later steps only on controlled or minor pulses
// - Read picks sequence by address class
// - Drum read sends read plus drum reference
// - Drum range 40000-77777 wraps to 40000
// - Addresses 00000-01777 are rapid-access core
// - Full core write: core write, clear latch
// - Full drum write: write, reference, clear latch
// - Full quotient write: quotient write, clear latch
// - Full accumulator write: accumulator write, clear
// - Full unassigned write: fault, clear latch
// - Lower write latch; core gets lower write
// - Lower drum write plus drum reference
// - Lower write elsewhere: fault, clear latch
// - Middle write latch; core or drum access
// - Middle write elsewhere: fault, clear latch
`timescale 1ns/1ps
module scs_sequencer #(
  parameter scs_pkg::scs_addr_t QUOT_ADDR = scs_pkg::SCS_QUOT_ADDR,
  parameter scs_pkg::scs_addr_t ACCUM_ADDR = scs_pkg::SCS_ACCUM_ADDR
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Commands and stepping pulses
  input wire scs_pkg::scs_cmd_s cmd,
  input wire logic controlled_clock_pulse,
  input wire logic minor_pulse,
  input wire logic addr_advance,
  input wire logic fault_clear,
  // Drum controller coincidence
  input wire logic drum_resume,
  // Subcommands and status
  output scs_pkg::scs_sub_s sub,
  output logic fault,
  output logic resume_main_pulse,
  output logic full_write_latch,
  output logic lower_field_write_latch,
  output logic middle_field_write_latch,
  // Held address
  output scs_pkg::scs_addr_t addr,
  output scs_pkg::scs_class_e addr_class
);

  // Any command starts a sequence
  wire logic any_cmd = cmd.read | cmd.write_full | cmd.write_lower | cmd.write_middle;

  // Only these pulses may move a pending write on
  wire logic step = controlled_clock_pulse | minor_pulse;

  // Class of the address offered with a read
  wire scs_pkg::scs_class_e cmd_class = scs_pkg::scs_classify(cmd.addr, QUOT_ADDR, ACCUM_ADDR);

  // Held address; any command reloads it
  scs_addr_unit #(
    .QUOT_ADDR(QUOT_ADDR),
    .ACCUM_ADDR(ACCUM_ADDR)
  ) u_addr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(any_cmd),
    .load_addr(cmd.addr),
    .advance(addr_advance),
    .addr(addr),
    .addr_class(addr_class)
  );

  // Held class decode
  wire logic is_core = (addr_class == scs_pkg::SCS_CLS_CORE);
  wire logic is_drum = (addr_class == scs_pkg::SCS_CLS_DRUM);
  wire logic is_quot = (addr_class == scs_pkg::SCS_CLS_QUOT);
  wire logic is_accum = (addr_class == scs_pkg::SCS_CLS_ACCUM);

  // Read dispatch happens with the command itself
  wire logic rd_core = cmd.read & (cmd_class == scs_pkg::SCS_CLS_CORE);
  wire logic rd_drum = cmd.read & (cmd_class == scs_pkg::SCS_CLS_DRUM);
  wire logic rd_quot = cmd.read & (cmd_class == scs_pkg::SCS_CLS_QUOT);
  wire logic rd_accum = cmd.read & (cmd_class == scs_pkg::SCS_CLS_ACCUM);
  wire logic rd_fault = cmd.read & (cmd_class == scs_pkg::SCS_CLS_NONE);

  // Pending writes fire on the next stepping pulse
  wire logic full_fire = full_write_latch & step;
  wire logic lower_fire = lower_field_write_latch & step;
  wire logic middle_fire = middle_field_write_latch & step;

  // Full-word write dispatch by class
  wire logic wf_core = full_fire & is_core;
  wire logic wf_drum = full_fire & is_drum;
  wire logic wf_quot = full_fire & is_quot;
  wire logic wf_accum = full_fire & is_accum;
  wire logic wf_fault = full_fire & (addr_class == scs_pkg::SCS_CLS_NONE);

  // Partial writes reach only core and drum
  wire logic wl_core = lower_fire & is_core;
  wire logic wl_drum = lower_fire & is_drum;
  wire logic wl_fault = lower_fire & ~is_core & ~is_drum;
  wire logic wm_core = middle_fire & is_core;
  wire logic wm_drum = middle_fire & is_drum;
  wire logic wm_fault = middle_fire & ~is_core & ~is_drum;

  // Every drum access carries a drum reference
  wire logic drum_ref = rd_drum | wf_drum | wl_drum | wm_drum;

  // Subcommand bundle for the next cycle
  wire scs_pkg::scs_sub_s next_sub = '{
    core_read: rd_core,
    core_write: wf_core,
    core_write_lower: wl_core,
    core_write_middle: wm_core,
    drum_read: rd_drum,
    drum_write: wf_drum,
    drum_write_lower: wl_drum,
    drum_write_middle: wm_drum,
    drum_reference: drum_ref,
    quot_read: rd_quot,
    quot_write: wf_quot,
    accum_read: rd_accum,
    accum_write: wf_accum
  };

  // Fault is sticky; a new fault beats a clear in the same cycle
  wire logic fault_set = rd_fault | wf_fault | wl_fault | wm_fault;
  wire logic next_fault = fault_set | (fault & ~fault_clear);

  // Latch sets with its command; a fresh command beats the clear
  wire logic next_full = cmd.write_full | (full_write_latch & ~step);
  wire logic next_lower = cmd.write_lower | (lower_field_write_latch & ~step);
  wire logic next_middle = cmd.write_middle | (middle_field_write_latch & ~step);

  // Write-request latches and fault
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      full_write_latch <= 1'b0;
      lower_field_write_latch <= 1'b0;
      middle_field_write_latch <= 1'b0;
      fault <= 1'b0;
    end else begin
      full_write_latch <= next_full;
      lower_field_write_latch <= next_lower;
      middle_field_write_latch <= next_middle;
      fault <= next_fault;
    end
  end

  // Subcommand pulses, one cycle each
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub <= scs_pkg::SCS_SUB_NONE;
    end else begin
      sub <= next_sub;
    end
  end

  // Coincidence from the drum controller goes on to the pulse distributor
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resume_main_pulse <= 1'b0;
    end else begin
      resume_main_pulse <= drum_resume;
    end
  end

  // Write latch is up the cycle after its command
  a_latch_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd.write_lower |=> lower_field_write_latch)
    else $error("lower-field latch not set by its command");

  // Without a stepping pulse a pending write just waits
  a_no_free_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (full_write_latch && !step) |=> (full_write_latch && !sub.core_write && !sub.drum_write))
    else $error("full write advanced without a stepping pulse");

  // Drum read sends read and reference together
  a_drum_read_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd.read && cmd.addr >= scs_pkg::SCS_DRUM_BASE) |=> (sub.drum_read && sub.drum_reference))
    else $error("drum read missing read or reference");

  // Read to the quotient register address goes to the register controller only
  a_read_class: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd.read && cmd.addr == QUOT_ADDR) |=> (sub.quot_read && !sub.core_read && !sub.drum_read))
    else $error("quotient read dispatched to wrong controller");

  // Resume follows the drum controller by one cycle
  a_resume_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    resume_main_pulse == $past(drum_resume))
    else $error("resume did not follow drum coincidence");

  // Full core write fires and the latch drops
  a_full_core: assert property (@(posedge core_clk) disable iff (!rst_n)
    (full_write_latch && step && is_core && !cmd.write_full)
      |=> (sub.core_write && !full_write_latch))
    else $error("full core write not dispatched or latch kept");

  // Full drum write carries its reference
  a_full_drum: assert property (@(posedge core_clk) disable iff (!rst_n)
    (full_write_latch && step && is_drum && !cmd.write_full)
      |=> (sub.drum_write && sub.drum_reference && !full_write_latch))
    else $error("full drum write incomplete");

  // Quotient full write
  a_full_quot: assert property (@(posedge core_clk) disable iff (!rst_n)
    (full_write_latch && step && is_quot) |=> (sub.quot_write && !sub.accum_write))
    else $error("quotient write not dispatched");

  // Accumulator full write
  a_full_accum: assert property (@(posedge core_clk) disable iff (!rst_n)
    (full_write_latch && step && is_accum) |=> (sub.accum_write && !sub.quot_write))
    else $error("accumulator write not dispatched");

  // Unassigned full write: fault and nothing else
  a_full_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    (full_write_latch && step && addr_class == scs_pkg::SCS_CLS_NONE && !cmd.write_full)
      |=> (fault && sub == scs_pkg::SCS_SUB_NONE && !full_write_latch))
    else $error("unassigned full write did not fault cleanly");

  // Lower core write
  a_lower_core: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lower_field_write_latch && step && is_core && !cmd.write_lower)
      |=> (sub.core_write_lower && !lower_field_write_latch))
    else $error("lower core write not dispatched");

  // Lower drum write with reference
  a_lower_drum: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lower_field_write_latch && step && is_drum) |=> (sub.drum_write_lower && sub.drum_reference))
    else $error("lower drum write incomplete");

  // Lower write elsewhere faults
  a_lower_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lower_field_write_latch && step && !is_core && !is_drum && !cmd.write_lower)
      |=> (fault && !sub.core_write_lower && !sub.drum_write_lower && !lower_field_write_latch))
    else $error("lower write outside core and drum did not fault");

  // Middle write to core or drum
  // Class picks the controller; a drum address also needs the reference
  a_middle_send: assert property (@(posedge core_clk) disable iff (!rst_n)
    (middle_field_write_latch && step && (is_core || is_drum))
      |=> ((sub.core_write_middle == $past(is_core))
        && (sub.drum_write_middle == $past(is_drum))
        && (sub.drum_reference || !$past(is_drum))))
    else $error("middle write not dispatched");

  // Middle write elsewhere faults
  a_middle_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    (middle_field_write_latch && step && !is_core && !is_drum && !cmd.write_middle)
      |=> (fault && !sub.core_write_middle && !sub.drum_write_middle && !middle_field_write_latch))
    else $error("middle write outside core and drum did not fault");

  // Full-word latch is up the cycle after its command
  a_full_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd.write_full |=> full_write_latch)
    else $error("full-word latch not set by its command");

  // Middle-field latch is up the cycle after its command
  a_middle_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd.write_middle |=> middle_field_write_latch)
    else $error("middle-field latch not set by its command");

  // Lower-field request holds until a stepping pulse
  a_lower_waits: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lower_field_write_latch && !step)
      |=> (lower_field_write_latch && !sub.core_write_lower && !sub.drum_write_lower))
    else $error("lower write advanced without a stepping pulse");

  // Middle-field request holds until a stepping pulse
  a_middle_waits: assert property (@(posedge core_clk) disable iff (!rst_n)
    (middle_field_write_latch && !step)
      |=> (middle_field_write_latch && !sub.core_write_middle && !sub.drum_write_middle))
    else $error("middle write advanced without a stepping pulse");

  // A step with nothing pending and no command sends nothing
  a_idle_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (step && !full_write_latch && !lower_field_write_latch && !middle_field_write_latch
      && !any_cmd) |=> (sub == scs_pkg::SCS_SUB_NONE))
    else $error("stepping pulse produced a subcommand with nothing pending");

  // Rapid-access read goes to the core controller only
  a_core_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd.read && cmd.addr <= scs_pkg::SCS_CORE_TOP)
      |=> (sub.core_read && !sub.drum_read && !sub.quot_read && !sub.accum_read))
    else $error("rapid-access read dispatched to wrong controller");

  // Accumulator read goes to the register controller only
  a_accum_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd.read && cmd.addr == ACCUM_ADDR) |=> (sub.accum_read && !sub.quot_read))
    else $error("accumulator read dispatched to wrong controller");

  // No drum access ever leaves without its reference
  a_drum_ref_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sub.drum_read || sub.drum_write || sub.drum_write_lower || sub.drum_write_middle)
      |-> sub.drum_reference)
    else $error("drum access sent without drum reference");

  // Fault stays up until it is cleared
  a_fault_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fault && !fault_clear) |=> fault)
    else $error("fault dropped without a clear");

endmodule : scs_sequencer

/* File: common/scs_pkg.sv */
/*
  Shared definitions for the storage class sequencer: address map,
  storage classes, command and subcommand bundles, class decoding.
  Assumes a single core clock and 15-bit storage addresses.
*/
package scs_pkg;

  // Address width and storage map
  localparam int SCS_ADDR_W = 15;
  typedef logic [SCS_ADDR_W-1:0] scs_addr_t;
  localparam scs_addr_t SCS_DRUM_BASE = 15'h4000;   // First drum address
  localparam scs_addr_t SCS_DRUM_TOP = 15'h7FFF;    // Last drum address
  localparam scs_addr_t SCS_CORE_TOP = 15'h03FF;    // Last rapid-access address
  localparam scs_addr_t SCS_QUOT_ADDR = 15'h2000;   // Quotient register, plain default
  localparam scs_addr_t SCS_ACCUM_ADDR = 15'h2001;  // Accumulator, plain default
  localparam scs_addr_t SCS_DRUM_MASK = 15'h3FFF;   // Bits that count inside drum
  localparam scs_addr_t SCS_PAGE_MASK = 15'h03FF;   // Bits that count elsewhere
  localparam scs_addr_t SCS_ADDR_ONE = 15'h0001;    // Advance step
  localparam scs_addr_t SCS_ADDR_RST = 15'h0000;    // Address after reset

  // Storage classes
  typedef enum logic [2:0] {
    SCS_CLS_CORE = 3'b000,
    SCS_CLS_DRUM = 3'b001,
    SCS_CLS_QUOT = 3'b010,
    SCS_CLS_ACCUM = 3'b011,
    SCS_CLS_NONE = 3'b100
  } scs_class_e;

  // Commands from the command timing control, one-cycle pulses
  typedef struct packed {
    logic read;           // Initiate read
    logic write_full;     // Initiate write, bits 0-35
    logic write_lower;    // Initiate write, bits 0-14
    logic write_middle;   // Initiate write, bits 15-29
    scs_addr_t addr;      // Storage address
  } scs_cmd_s;

  // Subcommands to the access controllers, one-cycle pulses
  typedef struct packed {
    logic core_read;
    logic core_write;
    logic core_write_lower;
    logic core_write_middle;
    logic drum_read;
    logic drum_write;
    logic drum_write_lower;
    logic drum_write_middle;
    logic drum_reference;
    logic quot_read;
    logic quot_write;
    logic accum_read;
    logic accum_write;
  } scs_sub_s;

  localparam scs_sub_s SCS_SUB_NONE = '0;  // No subcommand

  // Class of an address; register addresses are passed in
  function automatic scs_class_e scs_classify(input scs_addr_t a, input scs_addr_t q,
                                              input scs_addr_t acc);
    if (a >= SCS_DRUM_BASE) begin
      return SCS_CLS_DRUM;
    end else if (a <= SCS_CORE_TOP) begin
      return SCS_CLS_CORE;
    end else if (a == q) begin
      return SCS_CLS_QUOT;
    end else if (a == acc) begin
      return SCS_CLS_ACCUM;
    end
    return SCS_CLS_NONE;
  endfunction : scs_classify

endpackage : scs_pkg

/* File: src/scs_addr_unit.sv */
/*
  Held storage address with class decode and advance that wraps inside drum or a 1024-address page.
  Assumes load and advance are single-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
module scs_addr_unit #(
  parameter scs_pkg::scs_addr_t QUOT_ADDR = scs_pkg::SCS_QUOT_ADDR,
  parameter scs_pkg::scs_addr_t ACCUM_ADDR = scs_pkg::SCS_ACCUM_ADDR
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Load and advance
  input wire logic load,
  input wire scs_pkg::scs_addr_t load_addr,
  input wire logic advance,
  // Held address and its class
  output scs_pkg::scs_addr_t addr,
  output scs_pkg::scs_class_e addr_class
);

  // Carry is cut at the drum boundary, or at a 1024-address page outside drum, so the count wraps in place
  wire scs_pkg::scs_addr_t count_mask =
    (addr >= scs_pkg::SCS_DRUM_BASE) ? scs_pkg::SCS_DRUM_MASK : scs_pkg::SCS_PAGE_MASK;
  wire scs_pkg::scs_addr_t bumped = addr + scs_pkg::SCS_ADDR_ONE;
  wire scs_pkg::scs_addr_t advanced = (addr & ~count_mask) | (bumped & count_mask);
  // Load beats advance when both arrive
  wire scs_pkg::scs_addr_t next_addr = load ? load_addr : (advance ? advanced : addr);

  // Address and registered class
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr <= scs_pkg::SCS_ADDR_RST;
      addr_class <= scs_pkg::SCS_CLS_CORE;
    end else begin
      addr <= next_addr;
      addr_class <= scs_pkg::scs_classify(next_addr, QUOT_ADDR, ACCUM_ADDR);
    end
  end

  // Drum top wraps to drum base
  a_drum_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (advance && !load && addr == scs_pkg::SCS_DRUM_TOP) |=> addr == scs_pkg::SCS_DRUM_BASE)
    else $error("drum address did not wrap to base");

  // Rapid-access range never leaves its class
  a_core_class: assert property (@(posedge core_clk) disable iff (!rst_n)
    (load && load_addr <= scs_pkg::SCS_CORE_TOP) |=> addr_class == scs_pkg::SCS_CLS_CORE)
    else $error("rapid-access address not classed as core");

endmodule : scs_addr_unit

/* File: verification/scs_far_side.sv */
/*
  Far-side model of the drum access controller for the storage class
  sequencer bench: watches the subcommands and reports coincidence.
  Assumes the same core_clk and rst_n as the sequencer.
*/
`timescale 1ns/1ps
module scs_far_side (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Subcommands from the sequencer, reply speed
  input wire scs_pkg::scs_sub_s sub,
  input wire logic slow,
  // Coincidence back to the sequencer
  output logic drum_resume
);
  // Cycles until coincidence, zero when idle
  int wait_left;

  // Search for the address, then one resume pulse on phase zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_left <= 0;
      drum_resume <= 1'b0;
    end else begin
      // One-cycle pulse, like a phase-zero strobe
      drum_resume <= (wait_left == 1);
      // A new reference restarts the search; slow mimics a long rotation
      if (sub.drum_reference) begin
        wait_left <= slow ? 9 : 2;
      end else if (wait_left > 0) begin
        wait_left <= wait_left - 1;
      end
    end
  end
endmodule : scs_far_side

/* File: verification/storage_class_dispatch_bench.sv */
/*
  Self-checking bench for the storage class sequencer: reads, the three
  write kinds, faults, address advance, drum resume and reset.
  Assumes default register addresses and inputs driven on falling edges.
*/
`timescale 1ns/1ps
module storage_class_dispatch_bench;
  // Stimulus
  logic core_clk;
  logic rst_n;
  scs_pkg::scs_cmd_s cmd;
  logic controlled_clock_pulse;
  logic minor_pulse;
  logic addr_advance;
  logic fault_clear;
  logic slow_resume;
  logic drum_resume;
  // Observed outputs
  scs_pkg::scs_sub_s sub;
  logic fault;
  logic resume_main_pulse;
  logic full_write_latch;
  logic lower_field_write_latch;
  logic middle_field_write_latch;
  scs_pkg::scs_addr_t addr;
  scs_pkg::scs_class_e addr_class;
  // Score
  int n_errors = 0;
  int samples_checked = 0;

  scs_sequencer i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .cmd(cmd),
    .controlled_clock_pulse(controlled_clock_pulse), .minor_pulse(minor_pulse),
    .addr_advance(addr_advance), .fault_clear(fault_clear), .drum_resume(drum_resume),
    .sub(sub), .fault(fault), .resume_main_pulse(resume_main_pulse),
    .full_write_latch(full_write_latch), .lower_field_write_latch(lower_field_write_latch),
    .middle_field_write_latch(middle_field_write_latch), .addr(addr), .addr_class(addr_class)
  );

  scs_far_side i_far (
    .core_clk(core_clk), .rst_n(rst_n), .sub(sub), .slow(slow_resume),
    .drum_resume(drum_resume)
  );

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Compare and count; four-state so an unknown never matches
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Sticky fault must drop after one clear pulse
  task automatic clr_fault();
    fault_clear = 1'b1;
    @(negedge core_clk);
    fault_clear = 1'b0;
    chk("fault cleared", fault, 16'h0000);
  endtask : clr_fault

  // Read: dispatch one cycle after the command, no step needed
  task automatic do_read(input scs_pkg::scs_addr_t a, input logic [12:0] e, input logic f);
    cmd.read = 1'b1;
    cmd.addr = a;
    @(negedge core_clk);
    cmd.read = 1'b0;
    chk("read sub", sub, e);
    chk("read fault", fault, f);
    chk("read addr", addr, a);
    @(negedge core_clk);
    chk("read sub gone", sub, 16'h0000);
    clr_fault();
  endtask : do_read

  // Write of one kind: latch, idle cycle without step, then step
  task automatic do_write(input int kind, input scs_pkg::scs_addr_t a, input logic [12:0] e,
                          input logic f, input logic use_minor);
    logic [2:0] lat;
    cmd.write_full = (kind == 0);
    cmd.write_lower = (kind == 1);
    cmd.write_middle = (kind == 2);
    cmd.addr = a;
    @(negedge core_clk);
    cmd.write_full = 1'b0;
    cmd.write_lower = 1'b0;
    cmd.write_middle = 1'b0;
    lat = {full_write_latch, lower_field_write_latch, middle_field_write_latch};
    chk("latch set", lat, 16'h0004 >> kind);
    @(negedge core_clk);
    lat = {full_write_latch, lower_field_write_latch, middle_field_write_latch};
    chk("latch waits for step", lat, 16'h0004 >> kind);
    chk("no access before step", sub, 16'h0000);
    // Both stepping sources are exercised across the table
    if (use_minor) begin
      minor_pulse = 1'b1;
    end else begin
      controlled_clock_pulse = 1'b1;
    end
    @(negedge core_clk);
    minor_pulse = 1'b0;
    controlled_clock_pulse = 1'b0;
    lat = {full_write_latch, lower_field_write_latch, middle_field_write_latch};
    chk("write sub", sub, e);
    chk("write fault", fault, f);
    chk("latch cleared", lat, 16'h0000);
    @(negedge core_clk);
    chk("write sub gone", sub, 16'h0000);
    clr_fault();
  endtask : do_write

  // Advance the held address once after loading it
  task automatic adv_scn(input scs_pkg::scs_addr_t a, input scs_pkg::scs_addr_t e,
                         input scs_pkg::scs_class_e c);
    cmd.read = 1'b1;
    cmd.addr = a;
    @(negedge core_clk);
    cmd.read = 1'b0;
    addr_advance = 1'b1;
    @(negedge core_clk);
    addr_advance = 1'b0;
    chk("advanced addr", addr, e);
    chk("advanced class", addr_class, c);
  endtask : adv_scn

  // Drum read, then resume from the far side passes on one cycle later
  task automatic resume_scn(input logic slow);
    logic seen;
    seen = 1'b0;
    slow_resume = slow;
    do_read(15'h4321, 13'h0110, 1'b0);
    for (int i = 0; i < 20 && !seen; i++) begin
      @(negedge core_clk);
      if (drum_resume === 1'b1) begin
        seen = 1'b1;
        @(negedge core_clk);
        chk("resume passed on", resume_main_pulse, 16'h0001);
        @(negedge core_clk);
        chk("resume one cycle", resume_main_pulse, 16'h0000);
      end
    end
    chk("resume arrived", seen, 16'h0001);
  endtask : resume_scn

  // Reset in mid-run drops a pending write and a standing fault
  task automatic rst_scn();
    cmd.read = 1'b1;
    cmd.addr = 15'h0400;
    @(negedge core_clk);
    cmd.read = 1'b0;
    cmd.write_full = 1'b1;
    @(negedge core_clk);
    cmd.write_full = 1'b0;
    rst_n = 1'b0;
    @(negedge core_clk);
    chk("reset latch", full_write_latch, 16'h0000);
    chk("reset fault", fault, 16'h0000);
    rst_n = 1'b1;
    controlled_clock_pulse = 1'b1;
    @(negedge core_clk);
    controlled_clock_pulse = 1'b0;
    chk("nothing pending", sub, 16'h0000);
  endtask : rst_scn

  // Hang guard, far beyond the roughly 120 cycles the run needs
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    cmd = '0;
    controlled_clock_pulse = 1'b0;
    minor_pulse = 1'b0;
    addr_advance = 1'b0;
    fault_clear = 1'b0;
    slow_resume = 1'b0;
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("reset sub", sub, 16'h0000);
    chk("reset latches", {full_write_latch, lower_field_write_latch}, 16'h0000);
    chk("reset middle", middle_field_write_latch, 16'h0000);
    rst_n = 1'b1;
    do_read(15'h0000, 13'h1000, 1'b0);
    do_read(15'h03FF, 13'h1000, 1'b0);
    do_read(15'h4000, 13'h0110, 1'b0);
    do_read(15'h7FFF, 13'h0110, 1'b0);
    do_read(15'h2000, 13'h0008, 1'b0);
    do_read(15'h2001, 13'h0002, 1'b0);
    do_read(15'h0400, 13'h0000, 1'b1);
    do_write(0, 15'h0010, 13'h0800, 1'b0, 1'b0);
    do_write(0, 15'h4010, 13'h0090, 1'b0, 1'b1);
    do_write(0, 15'h2000, 13'h0004, 1'b0, 1'b0);
    do_write(0, 15'h2001, 13'h0001, 1'b0, 1'b1);
    do_write(0, 15'h0400, 13'h0000, 1'b1, 1'b0);
    do_write(1, 15'h03FF, 13'h0400, 1'b0, 1'b0);
    do_write(1, 15'h7FFF, 13'h0050, 1'b0, 1'b1);
    do_write(1, 15'h2000, 13'h0000, 1'b1, 1'b0);
    do_write(1, 15'h2001, 13'h0000, 1'b1, 1'b1);
    do_write(2, 15'h0000, 13'h0200, 1'b0, 1'b1);
    do_write(2, 15'h4000, 13'h0030, 1'b0, 1'b0);
    do_write(2, 15'h2001, 13'h0000, 1'b1, 1'b0);
    do_write(2, 15'h3FFF, 13'h0000, 1'b1, 1'b1);
    adv_scn(15'h7FFF, 15'h4000, scs_pkg::SCS_CLS_DRUM);
    adv_scn(15'h4005, 15'h4006, scs_pkg::SCS_CLS_DRUM);
    adv_scn(15'h03FF, 15'h0000, scs_pkg::SCS_CLS_CORE);
    resume_scn(1'b0);
    resume_scn(1'b1);
    rst_scn();
    end_sim();
  end
endmodule : storage_class_dispatch_bench
